// [pwm_sub_pkg.sv]
`default_nettype none
package pwm_sub_pkg;
  // register word addresses (byte address / 4 not used: aligned words)
  localparam logic [3:0] ADDR_SIC    = 4'h0;
  localparam logic [3:0] ADDR_PERIOD = 4'h1;
  localparam logic [3:0] ADDR_WIDTH  = 4'h2;
  localparam logic [3:0] ADDR_COUNT  = 4'h3;
  localparam logic [3:0] ADDR_ARB    = 4'h4;
  localparam logic [3:0] ADDR_IACK   = 4'h5;

  // status/interrupt/control field positions
  localparam int FLAG_BIT  = 15;
  localparam int IL_HI     = 14;
  localparam int IL_LO     = 12;
  localparam int ARB3_BIT  = 11;
  localparam int PIN_BIT   = 8;
  localparam int LOAD_BIT  = 6;
  localparam int POL_BIT   = 5;
  localparam int EN_BIT    = 4;
  localparam int CLK_HI    = 2;
  localparam int CLK_LO    = 0;

  // reset and start values
  localparam logic [15:0] COUNT_START = 16'h0001;
  localparam logic [15:0] WIDTH_ZERO  = 16'h0000;
  localparam logic [2:0]  IL_OFF      = 3'h0;
  localparam logic [7:0]  PRESC_TOP   = 8'hFF;
endpackage
`default_nettype wire

// [pwm_submodule.sv]
// Operation
// - flag sets at every period completion
// - enabling sets flag at once
// - flag stays set until software clears
// - clear by read-one then write-zero only
// - flag held clear while disabled
// - nonzero level plus flag raises request
// - three-bit level selects request line
// - acknowledge compares level against processor mask
// - arbitration number is bit three plus field
// - read-only pin status mirrors output pin
// - load copies buffers, restarts counter, sets flag
// - load ignored while disabled
// - load restarts period without glitch
// - polarity and enable set pin level
// - disabled holds flop, prescaler, counter, comparators
// - disabled copies user registers continuously
// - enable rise sets flop, starts counter, flag
// - enabled runs from working buffers, refresh each period
// - clock-rate field selectable at any time
// - period moves at period end or load
`timescale 1ns/10ps
`default_nettype none
module pwm_submodule (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // interrupt request and acknowledge
  output logic [7:1]       irq_request,
  output logic [3:0]       arb_number,
  input  wire logic [2:0]  iack_mask,
  output logic             iack_respond,
  // output pin
  output logic             pwm_out
);

  // ==========================================================
  // bus handshake
  // ==========================================================
  logic req_ack;
  logic rd_fire;
  logic wr_fire;

  // one wait state: answer on the cycle after the request appears
  always_ff @(posedge clk) begin
    if (!nrst) begin
      req_ack <= 1'b0;
    end else begin
      req_ack <= (read | write) & ~req_ack;
    end
  end

  assign waitrequest = ~req_ack;
  assign rd_fire     = read & req_ack;
  assign wr_fire     = write & req_ack;

  // ==========================================================
  // control registers
  // ==========================================================
  logic [2:0]  irq_level;
  logic        arbitration_bit_three;
  logic [2:0]  arbitration_low_field;
  logic        output_polarity;
  logic        enable;
  logic [2:0]  clk_rate;
  logic [15:0] period_user_reg;
  logic [15:0] width_user_reg;
  logic        wr_sic;
  logic        lo_en;
  logic        hi_en;

  assign wr_sic = wr_fire && (address == pwm_sub_pkg::ADDR_SIC);
  assign lo_en  = byteenable[0];
  assign hi_en  = byteenable[1];

  // software-written fields; clock rate takes effect at any time
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_level             <= pwm_sub_pkg::IL_OFF;
      arbitration_bit_three <= 1'b0;
      arbitration_low_field <= 3'h0;
      output_polarity       <= 1'b0;
      enable                <= 1'b0;
      clk_rate              <= 3'h0;
      period_user_reg       <= 16'h0000;
      width_user_reg        <= 16'h0000;
    end else if (wr_fire) begin
      case (address)
        pwm_sub_pkg::ADDR_SIC: begin
          if (hi_en) begin
            irq_level             <= writedata[pwm_sub_pkg::IL_HI:pwm_sub_pkg::IL_LO];
            arbitration_bit_three <= writedata[pwm_sub_pkg::ARB3_BIT];
          end
          if (lo_en) begin
            output_polarity <= writedata[pwm_sub_pkg::POL_BIT];
            enable          <= writedata[pwm_sub_pkg::EN_BIT];
            clk_rate        <= writedata[pwm_sub_pkg::CLK_HI:pwm_sub_pkg::CLK_LO];
          end
        end
        pwm_sub_pkg::ADDR_PERIOD: begin
          if (lo_en) period_user_reg[7:0] <= writedata[7:0];
          if (hi_en) period_user_reg[15:8] <= writedata[15:8];
        end
        pwm_sub_pkg::ADDR_WIDTH: begin
          if (lo_en) width_user_reg[7:0] <= writedata[7:0];
          if (hi_en) width_user_reg[15:8] <= writedata[15:8];
        end
        pwm_sub_pkg::ADDR_ARB: begin
          if (lo_en) arbitration_low_field <= writedata[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // enable edge, load command, prescaler
  // ==========================================================
  logic       enable_q;
  logic       enable_rise;
  logic       load_cmd;
  logic [7:0] prescaler;
  logic       tick;

  assign enable_rise = enable & ~enable_q;
  // load only acts while enabled, low byte lane carries it
  assign load_cmd = wr_sic & lo_en & writedata[pwm_sub_pkg::LOAD_BIT] & enable;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= enable;
    end
  end

  // free prescaler, held in reset while disabled
  always_ff @(posedge clk) begin
    if (!nrst || !enable || load_cmd) begin
      prescaler <= 8'h00;
    end else begin
      prescaler <= prescaler + 8'h01;
    end
  end

  // tap select: /2 ... /128, top choice /256 of the prescaler
  always_comb begin
    case (clk_rate)
      3'h0:    tick = prescaler[0] == 1'b1;
      3'h1:    tick = prescaler[1:0] == 2'h3;
      3'h2:    tick = prescaler[2:0] == 3'h7;
      3'h3:    tick = prescaler[3:0] == 4'hF;
      3'h4:    tick = prescaler[4:0] == 5'h1F;
      3'h5:    tick = prescaler[5:0] == 6'h3F;
      3'h6:    tick = prescaler[6:0] == 7'h7F;
      default: tick = prescaler == pwm_sub_pkg::PRESC_TOP;
    endcase
  end

  // ==========================================================
  // counter, working buffers, output flip-flop
  // ==========================================================
  logic [15:0] period_counter;
  logic [15:0] period_working_buf;
  logic [15:0] width_working_buf;
  logic        out_ff;
  logic        period_end;
  logic        width_match;

  // comparators only active while enabled
  assign period_end  = enable_q & tick & (period_counter == period_working_buf);
  assign width_match = enable_q & tick & (period_counter == width_working_buf);

  // working buffers: follow user regs when disabled, else at period end or load
  always_ff @(posedge clk) begin
    if (!nrst) begin
      period_working_buf <= 16'h0000;
      width_working_buf  <= 16'h0000;
    end else if (!enable_q || period_end || load_cmd) begin
      period_working_buf <= period_user_reg;
      width_working_buf  <= width_user_reg;
    end
  end

  // counter stopped at one when disabled, reload on period end or load
  always_ff @(posedge clk) begin
    if (!nrst || !enable_q) begin
      period_counter <= pwm_sub_pkg::COUNT_START;
    end else if (load_cmd || period_end) begin
      period_counter <= pwm_sub_pkg::COUNT_START;
    end else if (tick) begin
      period_counter <= period_counter + 16'h0001;
    end
  end

  // output flop: set at enable, set at period start only for a nonzero width, cleared at width match
  always_ff @(posedge clk) begin
    if (!nrst || !enable) begin
      out_ff <= 1'b0;
    end else if (enable_rise) begin
      out_ff <= 1'b1;
    end else if (load_cmd) begin
      out_ff <= (width_user_reg != pwm_sub_pkg::WIDTH_ZERO);
    end else if (period_end) begin
      out_ff <= (width_user_reg != pwm_sub_pkg::WIDTH_ZERO);
    end else if (width_match) begin
      out_ff <= 1'b0;
    end
  end

  // pin level from polarity
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= out_ff ^ output_polarity;
    end
  end

  // ==========================================================
  // completion flag and interrupt
  // ==========================================================
  logic flag;
  logic flag_seen_one;
  logic flag_set;
  logic flag_clear;

  assign flag_set = enable_rise | period_end | load_cmd;
  assign flag_clear = wr_sic & hi_en & ~writedata[pwm_sub_pkg::FLAG_BIT] & flag_seen_one;

  // remembers a read of the flag as one, armed for the clear
  always_ff @(posedge clk) begin
    if (!nrst || !enable) begin
      flag_seen_one <= 1'b0;
    end else if (rd_fire && address == pwm_sub_pkg::ADDR_SIC) begin
      flag_seen_one <= flag;
    end else if (flag_clear) begin
      flag_seen_one <= 1'b0;
    end
  end

  // sticky flag, set wins over clear
  always_ff @(posedge clk) begin
    if (!nrst || !enable) begin
      flag <= 1'b0;
    end else if (flag_set) begin
      flag <= 1'b1;
    end else if (flag_clear) begin
      flag <= 1'b0;
    end
  end

  // one-hot request line per level, none at level zero
  generate
    for (genvar lvl = 1; lvl < 8; lvl++) begin : g_irq
      assign irq_request[lvl] = flag && (irq_level == 3'(lvl));
    end
  endgenerate

  assign arb_number   = {arbitration_bit_three, arbitration_low_field};
  assign iack_respond = flag && (irq_level != pwm_sub_pkg::IL_OFF)
                        && (irq_level > iack_mask);

  // ==========================================================
  // read data
  // ==========================================================
  logic [15:0] sic_view;

  // load reads zero, pin reflects driven level
  always_comb begin
    sic_view = 16'h0000;
    sic_view[pwm_sub_pkg::FLAG_BIT] = flag;
    sic_view[pwm_sub_pkg::IL_HI:pwm_sub_pkg::IL_LO] = irq_level;
    sic_view[pwm_sub_pkg::ARB3_BIT] = arbitration_bit_three;
    sic_view[pwm_sub_pkg::PIN_BIT] = pwm_out;
    sic_view[pwm_sub_pkg::POL_BIT] = output_polarity;
    sic_view[pwm_sub_pkg::EN_BIT] = enable;
    sic_view[pwm_sub_pkg::CLK_HI:pwm_sub_pkg::CLK_LO] = clk_rate;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      readdata <= 32'h0000_0000;
    end else if ((read | write) && !req_ack) begin
      case (address)
        pwm_sub_pkg::ADDR_SIC:    readdata <= {16'h0000, sic_view};
        pwm_sub_pkg::ADDR_PERIOD: readdata <= {16'h0000, period_user_reg};
        pwm_sub_pkg::ADDR_WIDTH:  readdata <= {16'h0000, width_user_reg};
        pwm_sub_pkg::ADDR_COUNT:  readdata <= {16'h0000, period_counter};
        pwm_sub_pkg::ADDR_ARB:    readdata <= {29'h0, arbitration_low_field};
        default:                  readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  // flag and enable
  chk_flag_disabled: assert property (@(posedge clk) disable iff (!nrst)
    !enable |=> !flag) else $error("flag set while disabled");
  chk_enable_flag: assert property (@(posedge clk) disable iff (!nrst)
    enable_rise |=> flag) else $error("enable did not set flag");
  chk_flag_sticky: assert property (@(posedge clk) disable iff (!nrst)
    flag && enable && !flag_clear |=> flag) else $error("flag lost");

  // software clear without a set in the same cycle
  chk_flag_clear: assert property (@(posedge clk) disable iff (!nrst)
    flag_clear && !flag_set |=> !flag)
    else $error("flag not cleared");

  // load command
  chk_load_restart: assert property (@(posedge clk) disable iff (!nrst)
    load_cmd |=> period_counter == pwm_sub_pkg::COUNT_START && flag)
    else $error("load did not restart");
  chk_load_ignored: assert property (@(posedge clk) disable iff (!nrst)
    wr_sic && !enable |-> !load_cmd) else $error("load while disabled");

  // load sets the flop only for a nonzero width
  chk_load_width: assert property (@(posedge clk) disable iff (!nrst)
    load_cmd && !enable_rise |=> out_ff == (width_working_buf != pwm_sub_pkg::WIDTH_ZERO))
    else $error("load flop level wrong");

  // pin levels
  chk_pin_idle: assert property (@(posedge clk) disable iff (!nrst)
    !enable && !enable_q ##1 !enable |-> pwm_out == $past(output_polarity))
    else $error("idle pin level wrong");

  // pin is the flop through polarity, one cycle later
  chk_pin_follow: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> pwm_out == ($past(out_ff) ^ $past(output_polarity)))
    else $error("pin does not follow flop");

  // interrupt request and acknowledge
  chk_irq_gate: assert property (@(posedge clk) disable iff (!nrst)
    irq_level == pwm_sub_pkg::IL_OFF |-> irq_request == 7'h00)
    else $error("request at level zero");
  chk_irq_raise: assert property (@(posedge clk) disable iff (!nrst)
    flag && irq_level != pwm_sub_pkg::IL_OFF |-> irq_request != 7'h00)
    else $error("no request with flag");

  // acknowledge answers a level above the mask
  chk_iack_level: assert property (@(posedge clk) disable iff (!nrst)
    flag && irq_level > iack_mask |-> iack_respond)
    else $error("no acknowledge answer");

  // arbitration number is the two fields joined
  chk_arb_number: assert property (@(posedge clk) disable iff (!nrst)
    arb_number == {arbitration_bit_three, arbitration_low_field})
    else $error("arbitration number wrong");

  // counter and buffers
  chk_counter_hold: assert property (@(posedge clk) disable iff (!nrst)
    !enable_q |=> $past(enable_q) || period_counter == pwm_sub_pkg::COUNT_START)
    else $error("counter moved while disabled");

  // enabling starts the pulse from count one
  chk_start_count: assert property (@(posedge clk) disable iff (!nrst)
    enable_rise |=> out_ff && period_counter == pwm_sub_pkg::COUNT_START)
    else $error("enable start wrong");

  // disabled buffers track the user period
  chk_buffers_idle: assert property (@(posedge clk) disable iff (!nrst)
    !enable_q |=> period_working_buf == $past(period_user_reg))
    else $error("buffer not copied");

  // period end restarts count and pulse
  chk_period_restart: assert property (@(posedge clk) disable iff (!nrst)
    period_end && enable && !load_cmd |=> period_counter == pwm_sub_pkg::COUNT_START
    && out_ff == (width_working_buf != pwm_sub_pkg::WIDTH_ZERO))
    else $error("period restart wrong");

  // width match ends the pulse
  chk_width_clear: assert property (@(posedge clk) disable iff (!nrst)
    width_match && enable && !enable_rise && !load_cmd && !period_end |=> !out_ff)
    else $error("pulse not ended");

  // bus answer one cycle after the request
  chk_wait_answer: assert property (@(posedge clk) disable iff (!nrst)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("no bus answer");
endmodule
`default_nettype wire

// [pwm_load.sv]
`timescale 1ns/10ps
`default_nettype none
// load on the output pin: counts high cycles and rising edges
module pwm_load (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // counter clear from the bench
  input  wire logic        clr,
  // pin and measurements
  input  wire logic        pin,
  output logic [15:0]      high_cnt,
  output logic [15:0]      rise_cnt
);
  logic last;
  // ==========================================================
  // measurement
  // pin sampled every cycle, counts restart on clear
  always_ff @(posedge clk) begin
    last <= pin;
    if (!nrst || clr) begin
      high_cnt <= 16'h0000;
      rise_cnt <= 16'h0000;
    end else begin
      high_cnt <= high_cnt + 16'(pin);
      rise_cnt <= rise_cnt + 16'(pin & ~last);
    end
  end
endmodule
`default_nettype wire

// [tb_pwm_submodule.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_pwm_submodule;
  localparam logic [3:0] A_SIC = pwm_sub_pkg::ADDR_SIC;
  logic        clk, nrst, read, write, waitrequest, iack_respond, pwm_out, clr;
  logic [3:0]  address, byteenable, arb_number;
  logic [31:0] writedata, readdata, q;
  logic [7:1]  irq_request;
  logic [2:0]  iack_mask, lvl, arb;
  logic [15:0] high_cnt, rise_cnt;
  int          err_total, comparisons, i;
  int          cycles = 0;
  pwm_submodule dut (.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq_request(irq_request), .arb_number(arb_number),
    .iack_mask(iack_mask), .iack_respond(iack_respond), .pwm_out(pwm_out));
  pwm_load load (.clk(clk), .nrst(nrst), .clr(clr), .pin(pwm_out), .high_cnt(high_cnt),
    .rise_cnt(rise_cnt));
  // ==========================================================
  // helpers
  // status word as written and read back
  function automatic logic [15:0] sic(input logic f, input logic [2:0] l, input logic pn,
      input logic ld, input logic p, input logic e, input logic [2:0] c);
    sic = {f, l, 1'b1, 2'b00, pn, 1'b0, ld, p, e, 1'b0, c};
  endfunction
  // one request line per nonzero level
  function automatic logic [6:0] exp_irq(input logic [2:0] l);
    exp_irq = (l == 3'h0) ? 7'h00 : 7'(7'h01 << (l - 3'h1));
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (exp !== got) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= {16'h0000, d};
    read <= ~wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) check("waitrequest", 16'h0000, 16'h0001);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  // poll status until the completion flag shows
  task automatic wait_flag();
    int n;
    n = 0;
    q = 32'h0000_0000;
    while (q[pwm_sub_pkg::FLAG_BIT] !== 1'b1 && n < 4000) begin
      bus(1'b0, A_SIC, 16'h0000);
      n++;
    end
    check("flag wait", 16'h0001, 16'(q[pwm_sub_pkg::FLAG_BIT]));
  endtask
  task automatic test_done();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // clock and timeout
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      err_total++;
      test_done();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0000_0000;
    byteenable = 4'hF;
    iack_mask = 3'h0;
    clr = 1'b0;
    err_total = 0;
    comparisons = 0;
    i = $urandom(32'hFED1);
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    bus(1'b0, A_SIC, 16'h0000);
    check("sic reset", 16'h0000, q[15:0]);
    bus(1'b1, 4'h6, 16'hFFFF);
    bus(1'b0, 4'h6, 16'h0000);
    check("unmapped", 16'h0000, q[15:0]);
    // disabled: flag write and load ignored, pin follows polarity
    for (i = 0; i < 2; i++) begin
      bus(1'b1, A_SIC, sic(1'b1, 3'h0, 1'b0, 1'b1, i[0], 1'b0, 3'h0));
      repeat (3) @(posedge clk);
      check("pin idle", 16'(i[0]), 16'(pwm_out));
      bus(1'b0, A_SIC, 16'h0000);
      check("sic idle", sic(1'b0, 3'h0, i[0], 1'b0, i[0], 1'b0, 3'h0), q[15:0]);
    end
    bus(1'b0, pwm_sub_pkg::ADDR_COUNT, 16'h0000);
    check("count idle", 16'h0001, q[15:0]);
    // enable with random level and arbitration field
    lvl = 3'($urandom_range(7, 1));
    arb = 3'($urandom);
    bus(1'b1, pwm_sub_pkg::ADDR_ARB, {13'h0000, arb});
    bus(1'b1, pwm_sub_pkg::ADDR_PERIOD, 16'h0400);
    bus(1'b1, pwm_sub_pkg::ADDR_WIDTH, 16'h0200);
    bus(1'b1, A_SIC, sic(1'b0, lvl, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0));
    check("arb number", {12'h000, 1'b1, arb}, 16'(arb_number));
    bus(1'b0, A_SIC, 16'h0000);
    check("flag on enable", 16'h0001, 16'(q[pwm_sub_pkg::FLAG_BIT]));
    // every level with a random acknowledge mask
    for (i = 0; i < 8; i++) begin
      iack_mask <= 3'($urandom);
      bus(1'b1, A_SIC, sic(1'b1, i[2:0], 1'b0, 1'b0, 1'b0, 1'b1, 3'h0));
      check("irq line", 16'(exp_irq(i[2:0])), 16'(irq_request));
      check("iack", 16'(i != 0 && i[2:0] > iack_mask), 16'(iack_respond));
    end
    // read as one, then write zero clears
    bus(1'b0, A_SIC, 16'h0000);
    bus(1'b1, A_SIC, sic(1'b0, lvl, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0));
    check("irq cleared", 16'h0000, 16'(irq_request));
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wait_flag();
    check("pulses seen", 16'h0001, 16'(rise_cnt != 0 && high_cnt < 16'(cycles)));
    // flag just read as one: a zero write clears it
    bus(1'b1, A_SIC, sic(1'b0, lvl, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0));
    bus(1'b0, A_SIC, 16'h0000);
    check("flag cleared", 16'h0000, 16'(q[pwm_sub_pkg::FLAG_BIT]));
    repeat (2100) @(posedge clk);
    // zero write without a fresh read leaves flag set
    bus(1'b1, A_SIC, sic(1'b0, lvl, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0));
    bus(1'b0, A_SIC, 16'h0000);
    check("flag kept", 16'h0001, 16'(q[pwm_sub_pkg::FLAG_BIT]));
    bus(1'b1, A_SIC, sic(1'b0, lvl, 1'b0, 1'b0, 1'b0, 1'b1, 3'h7));
    // zero width then load on the slowest rate
    bus(1'b1, pwm_sub_pkg::ADDR_WIDTH, 16'h0000);
    bus(1'b1, A_SIC, sic(1'b0, lvl, 1'b0, 1'b1, 1'b0, 1'b1, 3'h7));
    clr <= 1'b1;
    bus(1'b0, pwm_sub_pkg::ADDR_COUNT, 16'h0000);
    clr <= 1'b0;
    check("count load", 16'h0001, q[15:0]);
    bus(1'b0, A_SIC, 16'h0000);
    check("load flag", 16'h0001, 16'(q[pwm_sub_pkg::FLAG_BIT]));
    check("load reads 0", 16'h0000, 16'(q[pwm_sub_pkg::LOAD_BIT]));
    repeat (200) @(posedge clk);
    check("no pulse", 16'h0000, high_cnt);
    // disable with inverted polarity
    bus(1'b1, A_SIC, sic(1'b0, lvl, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0));
    repeat (3) @(posedge clk);
    check("pin off", 16'h0001, 16'(pwm_out));
    bus(1'b0, A_SIC, 16'h0000);
    check("flag off", 16'h0000, 16'(q[pwm_sub_pkg::FLAG_BIT]));
    bus(1'b0, pwm_sub_pkg::ADDR_COUNT, 16'h0000);
    check("count off", 16'h0001, q[15:0]);
    test_done();
  end
endmodule
`default_nettype wire
